// ### rtl/path_trigger_map.svh
// register offsets, reset values, limits and timing counts of the path block
// assumes APB byte addresses, 32-bit aligned words, 25 MHz clock
`ifndef PATH_TRIGGER_MAP_SVH
`define PATH_TRIGGER_MAP_SVH

// ****************
// offsets
// ****************
`define RAMP_BASE        12'h000
`define WAIT_BASE        12'h040
`define PROTECTION_DECEL_SELECT_OFS         12'h080
`define TRIG_OFS         12'h084
`define RISE_OFS         12'h088
`define FALL_OFS         12'h08c
`define RETAIN_OFS       12'h090
`define FWD_LIM_OFS      12'h094
`define REV_LIM_OFS      12'h098
`define TURRET_OFS       12'h09c
`define BL_DIR_OFS       12'h0a0
`define BL_AMT_OFS       12'h0a4
`define BL_SMOOTH_OFS    12'h0a8
`define STATUS_OFS       12'h0ac

// ****************
// reset values and limits
// ****************
`define RAMP_RST         17'h00001
`define RAMP_MIN         17'h00001
`define RAMP_MAX         17'h1000e
`define WAIT_MAX         15'h7fff
`define TRIG_HOME        16'h0000
`define TRIG_PATH_MAX    16'h003f
`define TRIG_STOP        16'h03e8
`define TRIG_DONE_ADD    16'h07d0
`define EVT_NIB_MAX      4'hd
`define EVT_PATH_BASE    6'h32
`define RETAIN_MASK      16'h0011
`define PROTECTION_DECEL_SELECT_MASK        32'hf0f0ffff
`define TURRET_MAX       16'h7fff
`define BL_DIR_MAX       2'h2
`define BL_SMOOTH_MAX    16'h2710

// status register fields
`define ST_FWD_ALM_BIT   0
`define ST_REV_ALM_BIT   1
`define ST_STATE_LSB     8

// ****************
// timing
// ****************
`define CLK_HZ           25000000
`define SUBTICK_US       100
`define SUBTICK_CYC      ((`CLK_HZ / 1000000) * `SUBTICK_US)
`define SUBTICKS_PER_MS  10

`endif

// ### rtl/path_trigger_pkg.sv
// types shared by the path trigger block
// assumes nothing beyond a SystemVerilog compiler
package path_trigger_pkg;

  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,
    ST_HOME   = 5'b00010,
    ST_RUN    = 5'b00100,
    ST_ISSUED = 5'b01000,
    ST_SETTLE = 5'b10000
  } path_state_t;

  typedef enum logic [1:0] {
    BL_OFF = 2'h0,
    BL_CCW = 2'h1,
    BL_CW  = 2'h2
  } backlash_dir_t;

endpackage : path_trigger_pkg

// ### rtl/ms_tick_gen.sv
// 0.1 ms and 1 ms tick generator
// assumes a free-running clock at the rate given to the parameters
`timescale 1ns/100ps
`include "path_trigger_map.svh"

module ms_tick_gen #(
  parameter int SUB_CYC = `SUBTICK_CYC,
  parameter int SUB_PER = `SUBTICKS_PER_MS
) (
  input  wire logic clk,
  input  wire logic reset,
  output logic      tick_sub,
  output logic      tick_ms
);

  logic [15:0] cyc_q;
  logic [3:0]  sub_q;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cyc_q    <= 16'h0000;
      tick_sub <= 1'b0;
    end
    else if (cyc_q == 16'(SUB_CYC - 1))
    begin
      cyc_q    <= 16'h0000;
      tick_sub <= 1'b1;
    end
    else
    begin
      cyc_q    <= cyc_q + 16'h0001;
      tick_sub <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      sub_q   <= 4'h0;
      tick_ms <= 1'b0;
    end
    else
    begin
      tick_ms <= 1'b0;
      if (tick_sub)
      begin
        if (sub_q == 4'(SUB_PER - 1))
        begin
          sub_q   <= 4'h0;
          tick_ms <= 1'b1;
        end
        else
        begin
          sub_q <= sub_q + 4'h1;
        end
      end
    end
  end

endmodule : ms_tick_gen

// ### rtl/edge_event_detect.sv
// per-input rising and falling edge pulses
// assumes inputs already synchronous to clk
`timescale 1ns/100ps

module edge_event_detect #(
  parameter int N = 4
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic [N-1:0] level,
  output logic      [N-1:0] rise,
  output logic      [N-1:0] fall
);

  logic [N-1:0] last_q;

  for (genvar i = 0; i < N; i++)
  begin : g_ch
    always_ff @(posedge clk or posedge reset)
    begin
      if (reset)
      begin
        last_q[i] <= 1'b0;
        rise[i]   <= 1'b0;
        fall[i]   <= 1'b0;
      end
      else
      begin
        last_q[i] <= level[i];
        rise[i]   <= level[i] & ~last_q[i];
        fall[i]   <= ~level[i] & last_q[i];
      end
    end
  end

endmodule : edge_event_detect

// ### rtl/inner_path_trigger_control.sv
// inner-register path trigger control with APB register file
// assumes a motion core that reports command issue and positioning done
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
`include "path_trigger_map.svh"

// How it works
// - writing 0 to the trigger register starts homing
// - writing 1 to 63 starts stored path n
// - writing 1000 stops the motion in progress
// - readback is n running, 1000+n issued, 2000+n positioned
// - rise map nibbles per event input; 1 to D start paths 51 to 63
// - fall map nibbles likewise on the inactive edge
// - protection decel register holds six selector nibbles at fixed bits
// - each selector nibble picks one of sixteen ramp times
// - sixteen ramp times, accepted 1 to 65550 ms
// - sixteen completion delays, accepted 0 to 32767 ms
// - retention bits: 0 keeps path memory, 1 discards at power-off
// - ccw move past forward soft limit raises forward alarm
// - cw move past reverse soft limit raises reverse alarm
// - soft limits compare raw command count before gearing
// - backlash option: 0 off, 1 ccw, 2 cw
// - backlash amount is signed 16-bit pulse count
// - backlash smoothing in 0.1 ms steps up to 10000
// - turret tool count 0 to 32767
module inner_path_trigger_control
  import path_trigger_pkg::*;
#(
  parameter int NPOS = 16,
  parameter int NEVT = 4
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        event_input_a,
  input  wire logic        event_input_b,
  input  wire logic        event_input_c,
  input  wire logic        event_input_d,
  input  wire logic        inner_register_position_mode,
  input  wire logic        motor_ccw,
  input  wire logic        motor_moving,
  input  wire logic [31:0] cmd_pulse_count,
  input  wire logic        motion_cmd_issued,
  input  wire logic        motion_pos_done,
  input  wire logic        homing_done,
  input  wire logic        homing_second_stage,
  input  wire logic        timeout_abs_error,
  input  wire logic        reverse_hard_bound,
  input  wire logic        forward_hard_bound,
  output logic             path_start,
  output logic      [5:0]  path_number,
  output logic             homing_start,
  output logic             stop_req,
  output logic      [16:0] path_ramp_ms,
  output logic             protect_active,
  output logic      [16:0] protect_ramp_ms,
  output logic             forward_overtravel_alarm,
  output logic             reverse_overtravel_alarm,
  output logic      [15:0] backlash_comp,
  output logic      [1:0]  path_retention_option,
  output logic      [14:0] turret_tool_count
);

  // ****************
  // register storage
  // ****************
  logic [16:0]   ramp_q [NPOS];
  logic [14:0]   wait_q [NPOS];
  logic [31:0]   protection_decel_select_q;
  logic [15:0]   rise_map_q;
  logic [15:0]   fall_map_q;
  logic [15:0]   retain_q;
  logic [31:0]   fwd_lim_q;
  logic [31:0]   rev_lim_q;
  logic [15:0]   turret_q;
  logic [1:0]    bl_dir_q;
  logic [15:0]   bl_amt_q;
  logic [15:0]   bl_smooth_q;
  logic [15:0]   trig_rb_q;
  path_state_t   state_q;
  logic [5:0]    cur_path_q;
  logic [14:0]   settle_q;

  logic          tick_sub;
  logic          tick_ms;
  logic [NEVT-1:0] ev_rise;
  logic [NEVT-1:0] ev_fall;

  logic          wr_en;
  logic          setup;
  logic [3:0]    widx;
  logic          in_ramp;
  logic          in_wait;
  logic          mapped;
  logic [31:0]   rd_mux;
  logic [15:0]   wr16;
  logic [16:0]   wr_ramp;

  ms_tick_gen u_tick (
    .clk      (clk),
    .reset    (reset),
    .tick_sub (tick_sub),
    .tick_ms  (tick_ms)
  );

  edge_event_detect #(.N(NEVT)) u_edge (
    .clk   (clk),
    .reset (reset),
    .level ({event_input_d, event_input_c, event_input_b, event_input_a}),
    .rise  (ev_rise),
    .fall  (ev_fall)
  );

  // ****************
  // APB decode
  // ****************
  assign setup   = psel & ~penable;
  assign wr_en   = psel & penable & pready & pwrite;
  assign widx    = paddr[5:2];
  assign in_ramp = (paddr[11:6] == 6'(`RAMP_BASE >> 6));
  assign in_wait = (paddr[11:6] == 6'(`WAIT_BASE >> 6));
  assign wr16    = pwdata[15:0];
  assign wr_ramp = (pwdata > 32'(`RAMP_MAX)) ? `RAMP_MAX :
                   (pwdata < 32'(`RAMP_MIN)) ? `RAMP_MIN : pwdata[16:0];

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    mapped = 1'b1;
    if (in_ramp)
      rd_mux = {15'h0000, ramp_q[widx]};
    else if (in_wait)
      rd_mux = {17'h00000, wait_q[widx]};
    else
      case (paddr)
        `PROTECTION_DECEL_SELECT_OFS:      rd_mux = protection_decel_select_q;
        `TRIG_OFS:      rd_mux = {16'h0000, trig_rb_q};
        `RISE_OFS:      rd_mux = {16'h0000, rise_map_q};
        `FALL_OFS:      rd_mux = {16'h0000, fall_map_q};
        `RETAIN_OFS:    rd_mux = {16'h0000, retain_q};
        `FWD_LIM_OFS:   rd_mux = fwd_lim_q;
        `REV_LIM_OFS:   rd_mux = rev_lim_q;
        `TURRET_OFS:    rd_mux = {16'h0000, turret_q};
        `BL_DIR_OFS:    rd_mux = {30'h00000000, bl_dir_q};
        `BL_AMT_OFS:    rd_mux = {16'h0000, bl_amt_q};
        `BL_SMOOTH_OFS: rd_mux = {16'h0000, bl_smooth_q};
        `STATUS_OFS:    rd_mux = {19'h00000, state_q, 6'h00,
                                  reverse_overtravel_alarm, forward_overtravel_alarm};
        default:        mapped = 1'b0;
      endcase
  end

  // one access cycle: answer prepared at setup
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      if (setup & ~pwrite)
        prdata <= rd_mux;
    end
  end

  // ****************
  // parameter registers
  // ****************
  for (genvar i = 0; i < NPOS; i++)
  begin : g_pos
    always_ff @(posedge clk or posedge reset)
    begin
      if (reset)
      begin
        ramp_q[i] <= `RAMP_RST;
        wait_q[i] <= 15'h0000;
      end
      else if (wr_en && widx == 4'(i))
      begin
        if (in_ramp)
          ramp_q[i] <= wr_ramp;
        if (in_wait)
          wait_q[i] <= (pwdata > 32'(`WAIT_MAX)) ? `WAIT_MAX : pwdata[14:0];
      end
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      protection_decel_select_q      <= 32'h0000_0000;
      rise_map_q  <= 16'h0000;
      fall_map_q  <= 16'h0000;
      retain_q    <= 16'h0000;
      fwd_lim_q   <= 32'h0000_0000;
      rev_lim_q   <= 32'h0000_0000;
      turret_q    <= 16'h0000;
      bl_dir_q    <= BL_OFF;
      bl_amt_q    <= 16'h0000;
      bl_smooth_q <= 16'h0000;
    end
    else if (wr_en)
    begin
      case (paddr)
        `PROTECTION_DECEL_SELECT_OFS:    protection_decel_select_q     <= pwdata & `PROTECTION_DECEL_SELECT_MASK;
        `RISE_OFS:    rise_map_q <= wr16;
        `FALL_OFS:    fall_map_q <= wr16;
        `RETAIN_OFS:  retain_q   <= wr16 & `RETAIN_MASK;
        `FWD_LIM_OFS: fwd_lim_q  <= pwdata;
        `REV_LIM_OFS: rev_lim_q  <= pwdata;
        `TURRET_OFS:  turret_q   <= (wr16 > `TURRET_MAX) ? `TURRET_MAX : wr16;
        `BL_DIR_OFS:
        begin
          if (pwdata <= 32'(`BL_DIR_MAX))
            bl_dir_q <= pwdata[1:0];
        end
        `BL_AMT_OFS:  bl_amt_q <= wr16;
        `BL_SMOOTH_OFS:
          bl_smooth_q <= (wr16 > `BL_SMOOTH_MAX) ? `BL_SMOOTH_MAX : wr16;
        default:;
      endcase
    end
  end

  // ****************
  // trigger decode: software write first, then event a..d
  // ****************
  logic       trig_wr;
  logic       go_home;
  logic       go_stop;
  logic       go_path;
  logic [5:0] go_num;
  logic       evt_hit;
  logic [5:0] evt_num;
  logic [3:0] nib;

  assign trig_wr = wr_en && (paddr == `TRIG_OFS) && (pwdata[31:16] == 16'h0000);

  always_comb
  begin
    evt_hit = 1'b0;
    evt_num = 6'h00;
    nib     = 4'h0;
    for (int i = NEVT - 1; i >= 0; i--)
    begin
      nib = ev_rise[i] ? rise_map_q[i*4 +: 4] : (ev_fall[i] ? fall_map_q[i*4 +: 4] : 4'h0);
      if (nib != 4'h0 && nib <= `EVT_NIB_MAX)
      begin
        evt_hit = 1'b1;
        evt_num = `EVT_PATH_BASE + {2'b00, nib};
      end
    end
  end

  always_comb
  begin
    go_home = 1'b0;
    go_stop = 1'b0;
    go_path = 1'b0;
    go_num  = 6'h00;
    if (trig_wr)
    begin
      if (wr16 == `TRIG_HOME)
        go_home = 1'b1;
      else if (wr16 <= `TRIG_PATH_MAX)
      begin
        go_path = 1'b1;
        go_num  = wr16[5:0];
      end
      else if (wr16 == `TRIG_STOP)
        go_stop = 1'b1;
      // 64 to 999 and above 1000 left without effect
    end
    else if (evt_hit && inner_register_position_mode)
    begin
      go_path = 1'b1;
      go_num  = evt_num;
    end
  end

  // ****************
  // path sequencer
  // ****************
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_q      <= ST_IDLE;
      cur_path_q   <= 6'h00;
      settle_q     <= 15'h0000;
      trig_rb_q    <= 16'h0000;
      path_start   <= 1'b0;
      path_number  <= 6'h00;
      homing_start <= 1'b0;
      stop_req     <= 1'b0;
      path_ramp_ms <= `RAMP_RST;
    end
    else
    begin
      path_start   <= go_path;
      homing_start <= go_home;
      stop_req     <= go_stop;
      if (go_stop)
        state_q <= ST_IDLE;
      else if (go_home)
      begin
        state_q   <= ST_HOME;
        trig_rb_q <= `TRIG_HOME;
      end
      else if (go_path)
      begin
        state_q      <= ST_RUN;
        cur_path_q   <= go_num;
        path_number  <= go_num;
        path_ramp_ms <= ramp_q[4'(go_num - 6'h01)];
        trig_rb_q    <= {10'h000, go_num};
      end
      else
        case (state_q)
          ST_IDLE:;
          ST_HOME:
            if (homing_done)
              state_q <= ST_IDLE;
          ST_RUN:
            if (motion_cmd_issued)
            begin
              state_q   <= ST_ISSUED;
              trig_rb_q <= `TRIG_STOP + {10'h000, cur_path_q};
            end
          ST_ISSUED:
            if (motion_pos_done)
            begin
              state_q  <= ST_SETTLE;
              settle_q <= wait_q[4'(cur_path_q - 6'h01)];
            end
          ST_SETTLE:
            if (settle_q == 15'h0000)
            begin
              state_q   <= ST_IDLE;
              trig_rb_q <= `TRIG_DONE_ADD + {10'h000, cur_path_q};
            end
            else if (tick_ms)
              settle_q <= settle_q - 15'h0001;
          default:
            state_q <= ST_IDLE;
        endcase
    end
  end

  // ****************
  // soft stroke limits and protection deceleration
  // ****************
  logic fwd_over;
  logic rev_over;
  logic [3:0] dsel;
  logic       dact;

  // raw command count, no gear applied
  assign fwd_over = inner_register_position_mode && motor_moving && motor_ccw &&
                    ($signed(cmd_pulse_count) > $signed(fwd_lim_q));
  assign rev_over = inner_register_position_mode && motor_moving && !motor_ccw &&
                    ($signed(cmd_pulse_count) < $signed(rev_lim_q));

  always_comb
  begin
    dact = 1'b1;
    if (homing_second_stage)
      dsel = protection_decel_select_q[31:28];
    else if (timeout_abs_error)
      dsel = protection_decel_select_q[23:20];
    else if (rev_over)
      dsel = protection_decel_select_q[15:12];
    else if (fwd_over)
      dsel = protection_decel_select_q[11:8];
    else if (reverse_hard_bound)
      dsel = protection_decel_select_q[7:4];
    else if (forward_hard_bound)
      dsel = protection_decel_select_q[3:0];
    else
    begin
      dsel = 4'h0;
      dact = 1'b0;
    end
  end

  logic clr_fwd;
  logic clr_rev;
  assign clr_fwd = wr_en && (paddr == `STATUS_OFS) && pwdata[`ST_FWD_ALM_BIT];
  assign clr_rev = wr_en && (paddr == `STATUS_OFS) && pwdata[`ST_REV_ALM_BIT];

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      forward_overtravel_alarm <= 1'b0;
      reverse_overtravel_alarm <= 1'b0;
      protect_active           <= 1'b0;
      protect_ramp_ms          <= `RAMP_RST;
    end
    else
    begin
      // set wins over clear
      forward_overtravel_alarm <= fwd_over | (forward_overtravel_alarm & ~clr_fwd);
      reverse_overtravel_alarm <= rev_over | (reverse_overtravel_alarm & ~clr_rev);
      protect_active           <= dact;
      protect_ramp_ms          <= ramp_q[dsel];
    end
  end

  // ****************
  // backlash compensation, rate limited one pulse per 0.1 ms
  // ****************
  logic [15:0] bl_target;
  assign bl_target = ((bl_dir_q == BL_CCW && motor_ccw) ||
                      (bl_dir_q == BL_CW && !motor_ccw)) ? bl_amt_q : 16'h0000;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      backlash_comp <= 16'h0000;
    else if (bl_smooth_q == 16'h0000)
      backlash_comp <= bl_target;
    else if (tick_sub && backlash_comp != bl_target)
    begin
      if ($signed(backlash_comp) < $signed(bl_target))
        backlash_comp <= backlash_comp + 16'h0001;
      else
        backlash_comp <= backlash_comp - 16'h0001;
    end
  end

  // ****************
  // plain setting outputs
  // ****************
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      path_retention_option <= 2'b00;
      turret_tool_count     <= 15'h0000;
    end
    else
    begin
      path_retention_option <= {retain_q[4], retain_q[0]};
      turret_tool_count     <= turret_q[14:0];
    end
  end

endmodule : inner_path_trigger_control

// ### sim/path_trigger_checker_asserts.sv
// checker on the path trigger block ports
// assumes one clock domain and the register map header
`timescale 1ns/100ps
`include "path_trigger_map.svh"

// ****************
// checker
// ****************
module path_trigger_checker (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        path_start,
  input wire logic [5:0]  path_number,
  input wire logic        homing_start,
  input wire logic        stop_req,
  input wire logic [16:0] path_ramp_ms,
  input wire logic        inner_register_position_mode,
  input wire logic        motor_moving,
  input wire logic        motor_ccw,
  input wire logic        forward_overtravel_alarm,
  input wire logic        reverse_overtravel_alarm
);
  logic        trg;
  logic [15:0] tv;
  logic        fwd_c;
  logic        rev_c;

  assign trg   = psel && penable && pready && pwrite && paddr == `TRIG_OFS && pwdata[31:16] == 16'h0;
  assign tv    = pwdata[15:0];
  assign fwd_c = inner_register_position_mode && motor_moving && motor_ccw;
  assign rev_c = inner_register_position_mode && motor_moving && !motor_ccw;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  a_home_start: assert property (trg && tv == 16'h0 |=> homing_start)
    else $error("homing not started");
  a_path_start: assert property (trg && tv inside {[1:63]} |=> path_start && path_number == $past(tv))
    else $error("path not started");
  a_bad_ignored: assert property (trg && tv inside {[64:999]} |=> !path_start && !homing_start && !stop_req)
    else $error("forbidden value acted on");
  a_stop_req: assert property (trg && tv == 16'd1000 |=> stop_req)
    else $error("stop not requested");
  a_fwd_alarm: assert property ($rose(forward_overtravel_alarm) |-> $past(fwd_c))
    else $error("forward alarm without ccw move");
  a_rev_alarm: assert property ($rose(reverse_overtravel_alarm) |-> $past(rev_c))
    else $error("reverse alarm without cw move");
  a_ramp_range: assert property (path_start |-> path_ramp_ms inside {[1:65550]})
    else $error("ramp out of range");
  a_start_single: assert property (path_start |-> !homing_start && !stop_req)
    else $error("two starts at once");

  c_path: cover property (path_start && path_number == 6'd63);
  c_home: cover property (homing_start);
  c_alarm: cover property ($rose(reverse_overtravel_alarm));
endmodule : path_trigger_checker

bind inner_path_trigger_control path_trigger_checker u_chk (
  .clk, .reset, .psel, .penable, .pwrite, .pready, .paddr, .pwdata, .path_start, .path_number, .homing_start,
  .stop_req, .path_ramp_ms, .inner_register_position_mode, .motor_moving, .motor_ccw, .forward_overtravel_alarm,
  .reverse_overtravel_alarm
);

// ### sim/motion_core_model.sv
// motion core model answering path and homing starts
// assumes one-cycle start pulses; done_dly above 4
`timescale 1ns/100ps

// ****************
// model
// ****************
module motion_core_model (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       path_start,
  input  wire logic       homing_start,
  input  wire logic [7:0] done_dly,
  output logic            motion_cmd_issued,
  output logic            motion_pos_done,
  output logic            homing_done
);
  logic [7:0] cnt_q;
  logic       busy_q;

  always_ff @(posedge clk or posedge reset)
    if (reset)
    begin
      cnt_q  <= 8'h00;
      busy_q <= 1'b0;
    end
    else if (path_start || homing_start)
    begin
      cnt_q  <= 8'h00;
      busy_q <= 1'b1;
    end
    else if (busy_q)
    begin
      cnt_q  <= cnt_q + 8'h01;
      busy_q <= cnt_q != done_dly;
    end

  assign motion_cmd_issued = busy_q && cnt_q == 8'h04;
  assign motion_pos_done   = busy_q && cnt_q == done_dly;
  assign homing_done       = motion_pos_done;
endmodule : motion_core_model

// ### sim/tb.sv
// self-checking bench for the path trigger block
// assumes the design, the checker and the motion core model
`timescale 1ns/100ps
`include "path_trigger_map.svh"

// ****************
// bench
// ****************
module tb;
  logic        clk, reset, psel, penable, pwrite, pready, pslverr, se;
  logic        mode, ccw, mov, iss, pdn, hdn, ps, hs, sr, pa, fa, ra;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, cnt, rv;
  logic [3:0]  ev, pv;
  logic [7:0]  dly;
  logic [5:0]  pn;
  logic [16:0] prm, ppm;
  logic [15:0] bc;
  logic [1:0]  pro;
  logic [14:0] ttc;
  int          mismatches, comparisons, n_path, n_home, n_stop, cyc, i, p, h, s;

  inner_path_trigger_control dut (
    .clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .event_input_a(ev[0]),
    .event_input_b(ev[1]), .event_input_c(ev[2]), .event_input_d(ev[3]),
    .inner_register_position_mode(mode), .motor_ccw(ccw), .motor_moving(mov), .cmd_pulse_count(cnt),
    .motion_cmd_issued(iss), .motion_pos_done(pdn), .homing_done(hdn), .homing_second_stage(pv[3]),
    .timeout_abs_error(pv[2]), .reverse_hard_bound(pv[1]), .forward_hard_bound(pv[0]), .path_start(ps),
    .path_number(pn), .homing_start(hs), .stop_req(sr), .path_ramp_ms(prm), .protect_active(pa),
    .protect_ramp_ms(ppm), .forward_overtravel_alarm(fa), .reverse_overtravel_alarm(ra),
    .backlash_comp(bc), .path_retention_option(pro), .turret_tool_count(ttc)
  );
  motion_core_model u_core (
    .clk, .reset, .path_start(ps), .homing_start(hs), .done_dly(dly),
    .motion_cmd_issued(iss), .motion_pos_done(pdn), .homing_done(hdn)
  );

  task apb(input logic [11:0] a, input logic [31:0] d, input logic w = 1'b1);
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rv = prdata;
    se = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task chk(input logic [31:0] v, input logic [31:0] e, input string n);
    comparisons++;
    if (v !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, v);
    end
  endtask : chk

  task rchk(input logic [11:0] a, input logic [31:0] e, input string n);
    apb(a, 32'h0, 1'b0);
    chk(rv, e, n);
  endtask : rchk

  task poll(input logic [31:0] e);
    for (i = 0; i < 40 && rv !== e; i++)
      apb(`TRIG_OFS, 32'h0, 1'b0);
    chk(rv, e, "readback");
  endtask : poll

  task settle(input int k);
    repeat (k) @(posedge clk);
  endtask : settle

  task bchk(input logic [15:0] e, input string n);
    for (i = 0; i < 20 && bc !== e; i++)
      @(posedge clk);
    chk(bc, e, n);
  endtask : bchk

  task t_regs;
    rchk(`RAMP_BASE, 32'h1, "ramp reset");
    apb(`RAMP_BASE + 12'h004, 32'h0);
    rchk(`RAMP_BASE + 12'h004, 32'h1, "ramp floor");
    apb(`RAMP_BASE + 12'h03c, 32'h1ffff);
    rchk(`RAMP_BASE + 12'h03c, 32'h1000e, "ramp top");
    apb(`WAIT_BASE + 12'h03c, 32'hffff);
    rchk(`WAIT_BASE + 12'h03c, 32'h7fff, "wait top");
    apb(`PROTECTION_DECEL_SELECT_OFS, 32'hffffffff);
    rchk(`PROTECTION_DECEL_SELECT_OFS, 32'hf0f0ffff, "decel fields");
    rchk(12'h0fc, 32'h0, "unmapped");
    chk(se, 1'b1, "unmapped error");
  endtask : t_regs

  task t_path;
    dly <= 8'd30;
    apb(`RAMP_BASE + 12'h008, 32'h5);
    apb(`WAIT_BASE + 12'h008, 32'h1);
    apb(`TRIG_OFS, 32'd3);
    rchk(`TRIG_OFS, 32'd3, "running");
    chk(pn, 6'd3, "path number");
    chk(prm, 17'h5, "path ramp");
    poll(32'd1003);
    settle(40);
    rchk(`TRIG_OFS, 32'd1003, "finish wait");
    settle(25000);
    poll(32'd2003);
  endtask : t_path

  task t_cmds;
    h = n_home;
    s = n_stop;
    p = n_path;
    apb(`TRIG_OFS, 32'd0);
    apb(`TRIG_OFS, 32'd64);
    apb(`TRIG_OFS, 32'd999);
    apb(`TRIG_OFS, 32'd1000);
    apb(`TRIG_OFS, 32'd63);
    settle(3);
    chk(n_home, h + 1, "homing");
    chk(n_stop, s + 1, "stop");
    chk(n_path, p + 1, "starts");
    chk(pn, 6'd63, "top path");
  endtask : t_cmds

  task t_events;
    mode <= 1'b1;
    apb(`RISE_OFS, 32'h00d1);
    apb(`FALL_OFS, 32'h0002);
    ev[0] <= 1'b1;
    settle(4);
    chk(pn, 6'd51, "rise path");
    ev[0] <= 1'b0;
    settle(4);
    chk(pn, 6'd52, "fall path");
    ev[1] <= 1'b1;
    settle(4);
    chk(pn, 6'd63, "rise top");
    p = n_path;
    ev[1] <= 1'b0;
    ev[2] <= 1'b1;
    settle(4);
    chk(n_path, p, "disabled");
  endtask : t_events

  task t_alarms;
    apb(`FWD_LIM_OFS, 32'd100);
    apb(`REV_LIM_OFS, 32'hffffff9c);
    mov <= 1'b1;
    ccw <= 1'b1;
    cnt <= 32'd100;
    settle(3);
    chk(fa, 1'b0, "at limit");
    cnt <= 32'd101;
    settle(3);
    chk({fa, ra}, 2'b10, "forward");
    ccw <= 1'b0;
    cnt <= 32'hffffff9b;
    settle(3);
    chk(ra, 1'b1, "reverse");
    cnt <= 32'h0;
    mov <= 1'b0;
    apb(`STATUS_OFS, 32'h3);
    settle(2);
    chk({fa, ra}, 2'b00, "cleared");
    apb(`PROTECTION_DECEL_SELECT_OFS, 32'hf0000002);
    pv <= 4'hf;
    settle(3);
    chk({pa, ppm}, {1'b1, 17'h1000e}, "protect order");
    pv <= 4'h1;
    settle(3);
    chk({pa, ppm}, {1'b1, 17'h5}, "protect");
    pv <= 4'h0;
  endtask : t_alarms

  task t_misc;
    apb(`BL_AMT_OFS, 32'hfffd);
    apb(`BL_DIR_OFS, 32'h1);
    mov <= 1'b1;
    ccw <= 1'b1;
    bchk(16'hfffd, "ccw comp");
    apb(`BL_DIR_OFS, 32'h2);
    bchk(16'h0, "cw option");
    ccw <= 1'b0;
    bchk(16'hfffd, "cw comp");
    apb(`BL_DIR_OFS, 32'h3);
    rchk(`BL_DIR_OFS, 32'h2, "bad dir");
    apb(`BL_SMOOTH_OFS, 32'hffff);
    rchk(`BL_SMOOTH_OFS, 32'h2710, "smooth top");
    apb(`RETAIN_OFS, 32'hffffffff);
    rchk(`RETAIN_OFS, 32'h11, "retention");
    chk(pro, 2'b11, "retention out");
    apb(`TURRET_OFS, 32'hffff);
    rchk(`TURRET_OFS, 32'h7fff, "turret");
    chk(ttc, 15'h7fff, "turret out");
  endtask : t_misc

  task complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc++;
    n_path += int'(ps === 1'b1);
    n_home += int'(hs === 1'b1);
    n_stop += int'(sr === 1'b1);
    if (cyc == 40000)
    begin
      mismatches++;
      complete_run;
    end
  end

  initial
  begin
    {reset, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
    {ev, mode, ccw, mov, cnt, pv, dly} = {4'h0, 3'h0, 32'h0, 4'h0, 8'd10};
    settle(20);
    reset <= 1'b0;
    t_regs;
    t_path;
    t_cmds;
    t_events;
    t_alarms;
    t_misc;
    complete_run;
  end
endmodule : tb
